/* File: bench/host_model.sv */
// host model driving supply, reset, wake and commands
`timescale 1ns/1ns
module host_model (
    input wire logic clock,
    input wire logic io_supply_rail,
    input wire logic power_off_ack,
    input wire logic command_ready,
    input wire logic primary_serial_clear_to_send_n,
    output logic baseband_supply,
    output logic reset_line_n,
    output logic wake_request,
    output logic software_reset_command,
    output logic power_off_command,
    output logic io_config_command,
    output logic io_config_fast_en,
    output logic io_config_slow_en,
    output int late_count
);
    initial
    begin
        {baseband_supply, reset_line_n, wake_request, software_reset_command} = 4'h6;
        {power_off_command, io_config_command, io_config_fast_en, io_config_slow_en} = 4'h0;
        late_count = 0;
    end
    // awaits one device event, booked late past its maximum
    task automatic await(input int sel, input logic lvl, input int lim);
        int n;
        logic v;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
            v = sel == 0 ? io_supply_rail : sel == 1 ? !primary_serial_clear_to_send_n :
                sel == 2 ? command_ready : power_off_ack;
        end while (v !== lvl && n <= lim);
        if (v !== lvl)
            late_count++;
    endtask
    task automatic set_pins(input logic s, input logic r, input logic w);
        baseband_supply <= s;
        reset_line_n <= r;
        wake_request <= w;
    endtask
    // which: 0 software reset, 1 power-off, 2 clock config
    task automatic pulse(input int which, input logic f, input logic s);
        @(posedge clock);
        io_config_fast_en <= f;
        io_config_slow_en <= s;
        software_reset_command <= which == 0;
        power_off_command <= which == 1;
        io_config_command <= which == 2;
        @(posedge clock);
        {software_reset_command, power_off_command, io_config_command} <= 3'h0;
    endtask
    task automatic power_off(input logic remove);
        pulse(1, 1'b0, 1'b0);
        await(3, 1'b1, 4);
        wake_request <= 1'b0;
        await(0, 1'b0, 16);
        if (remove)
            baseband_supply <= 1'b0;
    endtask
    task automatic emergency();
        reset_line_n <= 1'b0;
        await(0, 1'b0, 300);
        baseband_supply <= 1'b0;
        // stands in for the supply discharging below its restart level
        repeat (1000) @(posedge clock);
        reset_line_n <= 1'b1;
    endtask
endmodule

/* File: bench/module_power_reset_sequencing_bench.sv */
// self-checking bench for the power sequencer
`timescale 1ns/1ns
module module_power_reset_sequencing_bench;
    localparam int P_REL = 20;
    localparam int P_RAIL = 15;
    localparam int P_RDY = 30;
    localparam int P_SW = 25;
    localparam int CTS_LIM = 1010;
    logic clock, rst_n, supply, rline_n, wake, swr, poff, cfg, cfg_f, cfg_s;
    logic released, rail, cts_n, ready, usb, ack, fast_en, slow_en, undef;
    logic f, s;
    int bad_count, num_checks, seed;
    power_sequencer #(.RESET_RELEASE_CYC(28'(P_REL)), .RAIL_UP_CYC(28'(P_RAIL)), .READY_CYC(28'(P_RDY)),
        .SW_RESET_CYC(28'(P_SW))) i_dut (.clock(clock), .rst_n(rst_n), .baseband_supply(supply),
        .reset_line_n(rline_n), .wake_request(wake), .software_reset_command(swr), .power_off_command(poff),
        .io_config_command(cfg), .io_config_fast_en(cfg_f), .io_config_slow_en(cfg_s),
        .reset_released(released), .io_supply_rail(rail), .primary_serial_clear_to_send_n(cts_n),
        .command_ready(ready), .usb_enumerated(usb), .power_off_ack(ack), .fast_clock_output_en(fast_en),
        .slow_clock_output_en(slow_en), .io_undefined(undef));
    host_model i_host (.clock(clock), .io_supply_rail(rail), .power_off_ack(ack), .command_ready(ready),
        .primary_serial_clear_to_send_n(cts_n), .baseband_supply(supply), .reset_line_n(rline_n),
        .wake_request(wake), .software_reset_command(swr), .power_off_command(poff), .io_config_command(cfg),
        .io_config_fast_en(cfg_f), .io_config_slow_en(cfg_s), .late_count());
    function automatic int lim(input int cyc);
        return cyc + 8;
    endfunction
    task automatic check(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic boot_check();
        i_host.await(0, 1'b1, lim(P_REL) + lim(P_RAIL));
        i_host.await(1, 1'b1, CTS_LIM);
        i_host.await(2, 1'b1, lim(P_RDY));
        check(usb, 1'b1);
        check(fast_en, 1'b0);
        check(slow_en, 1'b0);
        check(1'(i_host.late_count == 0), 1'b1);
    endtask
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        repeat (40000) @(posedge clock);
        bad_count++;
        $display("Error %0t: watchdog expired", $time);
        wrap_up();
    end
    initial
    begin
        seed = 32'h0B3FEABE;
        bad_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        repeat (4) @(posedge clock);
        check(fast_en, 1'b0);
        rst_n <= 1'b1;
        @(posedge clock);
        i_host.set_pins(1'b1, 1'b0, 1'b1);
        repeat (200) @(posedge clock);
        check(released, 1'b0);
        i_host.set_pins(1'b1, 1'b1, 1'b1);
        boot_check();
        $display("test boot done");
        // random settings first, then every combination, ending with both on
        for (int i = 0; i < 6; i++)
        begin
            {s, f} = i < 2 ? 2'($random(seed)) : 2'(i + 2);
            i_host.pulse(2, f, s);
            @(posedge clock);
            check(fast_en, f);
            check(slow_en, s);
        end
        i_host.pulse(0, 1'b0, 1'b0);
        @(posedge clock);
        check(ready, 1'b0);
        check(fast_en, 1'b0);
        check(rail, 1'b1);
        i_host.await(2, 1'b1, lim(P_SW));
        $display("test config and software reset done");
        i_host.set_pins(1'b1, 1'b0, 1'b1);
        repeat (300) @(posedge clock);
        check(rail, 1'b0);
        check(undef, 1'b1);
        repeat (700) @(posedge clock);
        check(released, 1'b0);
        i_host.set_pins(1'b1, 1'b1, 1'b1);
        boot_check();
        $display("test hardware reset done");
        i_host.power_off(1'b0);
        check(ready, 1'b0);
        i_host.set_pins(1'b1, 1'b1, 1'b1);
        i_host.await(0, 1'b1, lim(P_RAIL));
        boot_check();
        $display("test power off and wake done");
        i_host.emergency();
        check(rail, 1'b0);
        @(posedge clock);
        i_host.set_pins(1'b1, 1'b1, 1'b1);
        boot_check();
        i_host.power_off(1'b1);
        check(rail, 1'b0);
        $display("test supply removal done");
        wrap_up();
    end
endmodule

/* File: bench/power_sequencer_properties.sv */
// port-level assertions for the power sequencer
`timescale 1ns/1ns
module power_seq_checker #(
    parameter logic [power_seq_pkg::TIMER_W-1:0] RESET_RELEASE_CYC = 28'h0000014,
    parameter logic [power_seq_pkg::TIMER_W-1:0] RAIL_UP_CYC = 28'h000000F,
    parameter logic [power_seq_pkg::TIMER_W-1:0] READY_CYC = 28'h000001E,
    parameter logic [power_seq_pkg::TIMER_W-1:0] SW_RESET_CYC = 28'h0000019
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic baseband_supply,
    input wire logic reset_line_n,
    input wire logic wake_request,
    input wire logic software_reset_command,
    input wire logic power_off_command,
    input wire logic io_config_command,
    input wire logic io_config_fast_en,
    input wire logic io_config_slow_en,
    input wire logic reset_released,
    input wire logic io_supply_rail,
    input wire logic primary_serial_clear_to_send_n,
    input wire logic command_ready,
    input wire logic usb_enumerated,
    input wire logic power_off_ack,
    input wire logic fast_clock_output_en,
    input wire logic slow_clock_output_en,
    input wire logic io_undefined
);
    // margin covers the pin synchronisers and state register
    localparam int REL_LIM = RESET_RELEASE_CYC + 8;
    localparam int RAIL_LIM = RAIL_UP_CYC + 8;
    localparam int RDY_LIM = READY_CYC + 8;
    localparam int SW_LIM = SW_RESET_CYC + 8;
    logic [10:0] cts_wait_reg;
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // counter, since the clear-to-send wait is too long for a range
    always_ff @(posedge clock)
    begin
        if (!rst_n || !io_supply_rail || !primary_serial_clear_to_send_n)
            cts_wait_reg <= 11'h000;
        else
            cts_wait_reg <= cts_wait_reg + 11'h001;
    end
    rel_in_time_a: assert property ($rose(baseband_supply) && reset_line_n |-> ##[1:REL_LIM] reset_released)
        else $error("reset release late");
    rail_in_time_a: assert property ($rose(reset_released) |-> ##[1:RAIL_LIM] io_supply_rail)
        else $error("rail rise late");
    cts_in_time_a: assert property (cts_wait_reg <= 11'(power_seq_pkg::CTS_CYC))
        else $error("clear-to-send late");
    ready_in_time_a: assert property ($fell(primary_serial_clear_to_send_n) |-> ##[1:RDY_LIM] command_ready && usb_enumerated)
        else $error("readiness late");
    rail_drop_a: assert property (io_supply_rail && $fell(reset_line_n) |-> ##[1:4] !io_supply_rail && !reset_released && io_undefined)
        else $error("reset did not drop rail");
    sw_reset_return_a: assert property (command_ready && software_reset_command && !power_off_command |=> !command_ready ##[1:SW_LIM] command_ready)
        else $error("software reset return late");
    off_ack_pulse_a: assert property (command_ready && power_off_command |=> power_off_ack ##1 !power_off_ack)
        else $error("power-off ack wrong");
    cfg_apply_a: assert property (command_ready && io_config_command |=> fast_clock_output_en == $past(io_config_fast_en) && slow_clock_output_en == $past(io_config_slow_en))
        else $error("clock config not applied");
    clk_hold_a: assert property ($rose(fast_clock_output_en) || $rose(slow_clock_output_en) |-> $past(io_config_command))
        else $error("clock enabled without config");
    no_start_low_a: assert property (!reset_line_n && !$past(reset_line_n, 4) && !reset_released |=> !reset_released)
        else $error("started under reset");
    undef_quiet_a: assert property (io_undefined |-> !io_supply_rail && !command_ready)
        else $error("active while undefined");
    cover property (command_ready && power_off_command);
    cover property ($rose(io_undefined));
    cover property (command_ready && software_reset_command);
    cover property ($fell(primary_serial_clear_to_send_n));
endmodule
bind power_sequencer power_seq_checker #(.RESET_RELEASE_CYC(RESET_RELEASE_CYC), .RAIL_UP_CYC(RAIL_UP_CYC),
    .READY_CYC(READY_CYC), .SW_RESET_CYC(SW_RESET_CYC)) i_checker (.clock(clock), .rst_n(rst_n),
    .baseband_supply(baseband_supply), .reset_line_n(reset_line_n), .wake_request(wake_request),
    .software_reset_command(software_reset_command), .power_off_command(power_off_command),
    .io_config_command(io_config_command), .io_config_fast_en(io_config_fast_en),
    .io_config_slow_en(io_config_slow_en), .reset_released(reset_released), .io_supply_rail(io_supply_rail),
    .primary_serial_clear_to_send_n(primary_serial_clear_to_send_n), .command_ready(command_ready),
    .usb_enumerated(usb_enumerated), .power_off_ack(power_off_ack), .fast_clock_output_en(fast_clock_output_en),
    .slow_clock_output_en(slow_clock_output_en), .io_undefined(io_undefined));

/* File: src/delay_timer.sv */
// one-shot down counter that flags expiry a loaded number of cycles later
`timescale 1ns/1ns
module delay_timer (
    input wire logic clock,
    input wire logic rst_n,
    delay_timer_if.timer tif
);
    logic [power_seq_pkg::TIMER_W-1:0] count_reg;
    logic busy_reg;
    logic done_reg;

    assign tif.done = done_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (tif.load)
        begin
            count_reg <= tif.value;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
        end
        else if (busy_reg)
        begin
            if (count_reg <= power_seq_pkg::TIMER_W'(1))
            begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end
            else
            begin
                count_reg <= count_reg - power_seq_pkg::TIMER_W'(1);
            end
        end
    end
endmodule

/* File: src/delay_timer_if.sv */
// load and expiry signals between the sequencer and its delay timer
`timescale 1ns/1ns
interface delay_timer_if;
    logic load;
    logic [power_seq_pkg::TIMER_W-1:0] value;
    logic done;
    modport timer (input load, input value, output done);
    modport user (output load, output value, input done);
endinterface

/* File: src/power_seq_pkg.sv */
// shared constants for the module power and reset sequencer
package power_seq_pkg;
    localparam longint CLK_HZ = 64'd10_000_000;
    localparam int TIMER_W = 28;
    // documented time figures, in their own units
    localparam longint T_RESET_RELEASE_MS = 64'd200;
    localparam longint T_RAIL_UP_MS = 64'd60;
    localparam longint T_CTS_US = 64'd100;
    localparam longint T_READY_S = 64'd10;
    localparam longint T_RESET_MIN_US = 64'd100;
    localparam longint T_RAIL_DROP_US = 64'd30;
    localparam longint T_SW_RESET_S = 64'd10;
    // longest times round down, least times round up
    localparam logic [TIMER_W-1:0] RESET_RELEASE_CYC = TIMER_W'((T_RESET_RELEASE_MS * CLK_HZ) / 64'd1000);
    localparam logic [TIMER_W-1:0] RAIL_UP_CYC = TIMER_W'((T_RAIL_UP_MS * CLK_HZ) / 64'd1000);
    localparam logic [TIMER_W-1:0] CTS_CYC = TIMER_W'((T_CTS_US * CLK_HZ) / 64'd1_000_000);
    localparam logic [TIMER_W-1:0] READY_CYC = TIMER_W'(T_READY_S * CLK_HZ);
    localparam logic [TIMER_W-1:0] SW_RESET_CYC = TIMER_W'(T_SW_RESET_S * CLK_HZ);
    localparam logic [TIMER_W-1:0] RAIL_DROP_CYC = TIMER_W'((T_RAIL_DROP_US * CLK_HZ) / 64'd1_000_000);
    localparam int RESET_MIN_W = 11;
    localparam logic [RESET_MIN_W-1:0] RESET_MIN_CYC =
        RESET_MIN_W'((T_RESET_MIN_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
    // timer load and state register add two cycles; pin sync and start add three more
    localparam logic [TIMER_W-1:0] TIMER_PIPE_CYC = 28'h0000002;
    localparam logic [TIMER_W-1:0] RELEASE_PIPE_CYC = 28'h0000005;
    localparam int SYNC_W = 3;
    localparam int SYNC_SUPPLY = 0;
    localparam int SYNC_RESET = 1;
    localparam int SYNC_WAKE = 2;
    typedef enum logic [3:0] {
        ST_UNPOWERED,
        ST_RESET_DELAY,
        ST_RAIL_DELAY,
        ST_CTS_DELAY,
        ST_BOOT,
        ST_READY,
        ST_SW_RESET,
        ST_POWER_DOWN,
        ST_OFF_MODE,
        ST_HW_RESET
    } seq_state_e;
endpackage

/* File: src/power_sequencer.sv */
// device-side power-up, reset and power-down sequencer
// Function
// [RULE_01] after baseband supply arrives, release the internal reset within 200 ms
// [RULE_02] raise the I/O supply rail within 60 ms of reset release
// [RULE_03] assert primary clear-to-send within 100 us of the rail rising
// [RULE_04] signal command readiness within 10 s of clear-to-send
// [RULE_05] host holds the reset line low at least 100 us
// [RULE_06] reset line low drops the I/O rail within 30 us
// [RULE_07] after software reset, command readiness returns within 10 s
// [RULE_08] USB enumeration completes within clear-to-send plus readiness maxima of rail rise
// [RULE_09] host sends power-off command, then drops wake request on acknowledge
// [RULE_10] host removes supplies only once the I/O rail reads low
// [RULE_11] in off mode, a high wake request wakes the device
// [RULE_12] emergency removal: hold reset, await rail low, remove supplies, then release
// [RULE_13] reset held at least 100 us resets the device in any state
// [RULE_14] host must not pull reset low during a power cycle
// [RULE_15] during reset all device I/Os are undefined
// [RULE_16] host prefers software reset over the hardware reset line
// [RULE_17] clock outputs start disabled; only the config command changes them; the code also clears them on entering any state but ST_READY or ST_POWER_DOWN
// [RULE_18] start regardless of power switch, but never while reset is low
// [RULE_19] host times each awaited event against its maximum
`timescale 1ns/1ns
module power_sequencer #(
    parameter logic [power_seq_pkg::TIMER_W-1:0] RESET_RELEASE_CYC = power_seq_pkg::RESET_RELEASE_CYC,
    parameter logic [power_seq_pkg::TIMER_W-1:0] RAIL_UP_CYC = power_seq_pkg::RAIL_UP_CYC,
    parameter logic [power_seq_pkg::TIMER_W-1:0] READY_CYC = power_seq_pkg::READY_CYC,
    parameter logic [power_seq_pkg::TIMER_W-1:0] SW_RESET_CYC = power_seq_pkg::SW_RESET_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic baseband_supply,
    input wire logic reset_line_n,
    input wire logic wake_request,
    input wire logic software_reset_command,
    input wire logic power_off_command,
    input wire logic io_config_command,
    input wire logic io_config_fast_en,
    input wire logic io_config_slow_en,
    output logic reset_released,
    output logic io_supply_rail,
    output logic primary_serial_clear_to_send_n,
    output logic command_ready,
    output logic usb_enumerated,
    output logic power_off_ack,
    output logic fast_clock_output_en,
    output logic slow_clock_output_en,
    output logic io_undefined
);
    logic [power_seq_pkg::SYNC_W-1:0] pin_meta_reg;
    logic [power_seq_pkg::SYNC_W-1:0] pin_sync_reg;
    logic supply_ok;
    logic reset_low;
    logic wake_high;
    power_seq_pkg::seq_state_e state_reg;
    power_seq_pkg::seq_state_e state_next;
    logic load_reg;
    logic [power_seq_pkg::TIMER_W-1:0] value_reg;
    logic timer_expired;
    logic [power_seq_pkg::RESET_MIN_W-1:0] low_cnt_reg;
    logic reset_taken_reg;
    logic reset_released_reg;
    logic rail_reg;
    logic cts_n_reg;
    logic ready_reg;
    logic usb_reg;
    logic ack_reg;
    logic fast_en_reg;
    logic slow_en_reg;
    logic undefined_reg;

    delay_timer_if tif ();

    delay_timer u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .tif(tif)
    );

    // loads trimmed by the pipeline so each whole path still meets its maximum
    function automatic logic [power_seq_pkg::TIMER_W-1:0] delay_for(input power_seq_pkg::seq_state_e st);
        case (st)
            power_seq_pkg::ST_RESET_DELAY: delay_for = RESET_RELEASE_CYC - power_seq_pkg::RELEASE_PIPE_CYC;
            power_seq_pkg::ST_RAIL_DELAY: delay_for = RAIL_UP_CYC - power_seq_pkg::TIMER_PIPE_CYC;
            power_seq_pkg::ST_CTS_DELAY: delay_for = power_seq_pkg::CTS_CYC - power_seq_pkg::TIMER_PIPE_CYC;
            power_seq_pkg::ST_BOOT: delay_for = READY_CYC - power_seq_pkg::TIMER_PIPE_CYC;
            power_seq_pkg::ST_SW_RESET: delay_for = SW_RESET_CYC - power_seq_pkg::TIMER_PIPE_CYC;
            default: delay_for = power_seq_pkg::TIMER_W'(1);
        endcase
    endfunction

    // pins come from the host's domain
    genvar gi;
    generate
        for (gi = 0; gi < power_seq_pkg::SYNC_W; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                end
                else
                begin
                    pin_meta_reg[gi] <= (gi == power_seq_pkg::SYNC_RESET) ? ~reset_line_n :
                        ((gi == power_seq_pkg::SYNC_SUPPLY) ? baseband_supply : wake_request);
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate

    assign supply_ok = pin_sync_reg[power_seq_pkg::SYNC_SUPPLY];
    assign reset_low = pin_sync_reg[power_seq_pkg::SYNC_RESET];
    assign wake_high = pin_sync_reg[power_seq_pkg::SYNC_WAKE];
    assign tif.load = load_reg;
    assign tif.value = value_reg;
    // a stale expiry from the previous delay is masked in the load cycle
    assign timer_expired = tif.done && !load_reg;

    always_comb
    begin
        state_next = state_reg;
        if (!supply_ok)
        begin
            state_next = power_seq_pkg::ST_UNPOWERED;
        end
        else if (reset_low)
        begin
            // no start while reset is held; a running device drops into reset
            if (state_reg != power_seq_pkg::ST_UNPOWERED) // [RULE_18]
            begin
                state_next = power_seq_pkg::ST_HW_RESET; // [RULE_13]
            end
        end
        else
        begin
            case (state_reg)
                power_seq_pkg::ST_UNPOWERED:
                begin
                    // power switch input is ignored in unmanaged mode
                    state_next = power_seq_pkg::ST_RESET_DELAY; // [RULE_18]
                end
                power_seq_pkg::ST_RESET_DELAY:
                begin
                    if (timer_expired)
                    begin
                        state_next = power_seq_pkg::ST_RAIL_DELAY; // [RULE_01]
                    end
                end
                power_seq_pkg::ST_RAIL_DELAY:
                begin
                    if (timer_expired)
                    begin
                        state_next = power_seq_pkg::ST_CTS_DELAY; // [RULE_02]
                    end
                end
                power_seq_pkg::ST_CTS_DELAY:
                begin
                    if (timer_expired)
                    begin
                        state_next = power_seq_pkg::ST_BOOT; // [RULE_03]
                    end
                end
                power_seq_pkg::ST_BOOT, power_seq_pkg::ST_SW_RESET:
                begin
                    if (timer_expired)
                    begin
                        state_next = power_seq_pkg::ST_READY; // [RULE_04] [RULE_07]
                    end
                end
                power_seq_pkg::ST_READY:
                begin
                    if (power_off_command)
                    begin
                        state_next = power_seq_pkg::ST_POWER_DOWN;
                    end
                    else if (software_reset_command)
                    begin
                        state_next = power_seq_pkg::ST_SW_RESET;
                    end
                end
                power_seq_pkg::ST_POWER_DOWN:
                begin
                    // rail stays up until the host lets the wake request fall
                    if (!wake_high)
                    begin
                        state_next = power_seq_pkg::ST_OFF_MODE;
                    end
                end
                power_seq_pkg::ST_OFF_MODE:
                begin
                    if (wake_high)
                    begin
                        state_next = power_seq_pkg::ST_RAIL_DELAY; // [RULE_11]
                    end
                end
                power_seq_pkg::ST_HW_RESET:
                begin
                    // any release restarts the boot from reset release
                    state_next = power_seq_pkg::ST_RESET_DELAY;
                end
                default:
                begin
                    state_next = power_seq_pkg::ST_UNPOWERED;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_reg <= power_seq_pkg::ST_UNPOWERED;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // one load pulse on each state change
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            load_reg <= 1'b0;
            value_reg <= '0;
        end
        else
        begin
            load_reg <= (state_next != state_reg);
            value_reg <= delay_for(state_next);
        end
    end

    // reset held long enough is recorded as a full reset
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            low_cnt_reg <= '0;
            reset_taken_reg <= 1'b0;
        end
        else if (!reset_low)
        begin
            low_cnt_reg <= '0;
            reset_taken_reg <= 1'b0;
        end
        else if (low_cnt_reg < power_seq_pkg::RESET_MIN_CYC)
        begin
            low_cnt_reg <= low_cnt_reg + power_seq_pkg::RESET_MIN_W'(1);
        end
        else
        begin
            reset_taken_reg <= 1'b1; // [RULE_13]
        end
    end

    // pin levels follow the state being entered
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            reset_released_reg <= 1'b0;
            rail_reg <= 1'b0;
            cts_n_reg <= 1'b1;
            ready_reg <= 1'b0;
            usb_reg <= 1'b0;
            undefined_reg <= 1'b0;
        end
        else
        begin
            reset_released_reg <= (state_next != power_seq_pkg::ST_UNPOWERED) &&
                (state_next != power_seq_pkg::ST_RESET_DELAY) &&
                (state_next != power_seq_pkg::ST_HW_RESET); // [RULE_01]
            // rail drops three cycles after the pin falls, far inside the limit
            rail_reg <= (state_next == power_seq_pkg::ST_CTS_DELAY) ||
                (state_next == power_seq_pkg::ST_BOOT) ||
                (state_next == power_seq_pkg::ST_READY) ||
                (state_next == power_seq_pkg::ST_SW_RESET) ||
                (state_next == power_seq_pkg::ST_POWER_DOWN); // [RULE_02] [RULE_06]
            cts_n_reg <= !((state_next == power_seq_pkg::ST_BOOT) ||
                (state_next == power_seq_pkg::ST_READY) ||
                (state_next == power_seq_pkg::ST_SW_RESET) ||
                (state_next == power_seq_pkg::ST_POWER_DOWN)); // [RULE_03]
            ready_reg <= (state_next == power_seq_pkg::ST_READY) ||
                (state_next == power_seq_pkg::ST_POWER_DOWN); // [RULE_04] [RULE_07]
            // enumeration lands with readiness, inside the summed bound
            usb_reg <= (state_next == power_seq_pkg::ST_READY) ||
                (state_next == power_seq_pkg::ST_SW_RESET) ||
                (state_next == power_seq_pkg::ST_POWER_DOWN); // [RULE_08]
            undefined_reg <= (state_next == power_seq_pkg::ST_HW_RESET) || reset_taken_reg; // [RULE_15]
        end
    end

    // positive acknowledge of the power-off command
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= (state_reg == power_seq_pkg::ST_READY) &&
                (state_next == power_seq_pkg::ST_POWER_DOWN);
        end
    end

    // clock outputs off at every start; config only honoured when ready
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            fast_en_reg <= 1'b0;
            slow_en_reg <= 1'b0;
        end
        else if (state_next != power_seq_pkg::ST_READY)
        begin
            if (state_next != power_seq_pkg::ST_POWER_DOWN)
            begin
                fast_en_reg <= 1'b0; // [RULE_17]
                slow_en_reg <= 1'b0; // [RULE_17]
            end
        end
        else if (io_config_command && state_reg == power_seq_pkg::ST_READY)
        begin
            fast_en_reg <= io_config_fast_en; // [RULE_17]
            slow_en_reg <= io_config_slow_en; // [RULE_17]
        end
    end

    assign reset_released = reset_released_reg;
    assign io_supply_rail = rail_reg;
    assign primary_serial_clear_to_send_n = cts_n_reg;
    assign command_ready = ready_reg;
    assign usb_enumerated = usb_reg;
    assign power_off_ack = ack_reg;
    assign fast_clock_output_en = fast_en_reg;
    assign slow_clock_output_en = slow_en_reg;
    assign io_undefined = undefined_reg;
endmodule
